// ### ipdc_pkg.sv
// Constants and types shared by the idle and power-down controller
package ipdc_pkg;

  // Power control register location and value after reset
  localparam logic [7:0] POWER_CONTROL_ADDR  = 8'h87;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;

  // Power control register bit positions
  localparam int BIT_IDLE_REQ  = 0;
  localparam int BIT_PD_REQ    = 1;
  localparam int BIT_GFLAG_A   = 2;
  localparam int BIT_GFLAG_B   = 3;
  localparam int BIT_POWER_OFF = 4;
  localparam int BIT_RESERVED  = 5;
  localparam int BIT_FRAME_SEL = 6;
  localparam int BIT_BAUD_DBL  = 7;

  // Keyboard wake delay in clocks
  localparam int WAKE_KBD_CYCLES = 1024;

  // Least reset hold that ends idle, in oscillator periods
  localparam int IDLE_RESET_OSC_PERIODS = 24;

  // Controller states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_IDLE,
    ST_PD,
    ST_PD_EXT,
    ST_PD_KWAIT
  } ipdc_state_type;

endpackage

// ### ipdc_wake_if.sv
// Handshake between the controller and the keyboard wake timer
`timescale 1ns/1ps
`default_nettype none
interface ipdc_wake_if;
  logic start;
  logic busy;
  logic done;

  modport ctrl  (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

// ### ipdc_wake_timer.sv
// Keyboard wake delay timer, done in its last counted cycle
`timescale 1ns/1ps
`default_nettype none
module ipdc_wake_timer
  import ipdc_pkg::*;
#(
  parameter int CYCLES = WAKE_KBD_CYCLES
) (
  input  wire logic   clk_sys,
  input  wire logic   nrst,
  ipdc_wake_if.timer  wake
);
  localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic          busy;
  logic          next_busy;

  // Load on start, count down while busy
  always_comb begin
    next_cnt  = cnt;
    next_busy = busy;
    if (wake.start) begin
      next_cnt  = LOAD;
      next_busy = 1'b1;
    end else if (busy) begin
      if (cnt == '0) begin
        next_busy = 1'b0;
      end else begin
        next_cnt = cnt - CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt  <= '0;
      busy <= 1'b0;
    end else begin
      cnt  <= next_cnt;
      busy <= next_busy;
    end
  end

  // Done is combinational so the controller leaves in the same cycle
  assign wake.busy = busy;
  assign wake.done = busy && (cnt == '0);
endmodule
`default_nettype wire

// ### ipdc_power_ctrl.sv
// Idle and power-down controller with its power control register
`timescale 1ns/1ps
`default_nettype none
module ipdc_power_ctrl
  import ipdc_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_KBD_CYCLES
) (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  input  wire logic       instr_done,
  input  wire logic       irq_any,
  input  wire logic       ext_irq_zero_n,
  input  wire logic       ext_irq_one_n,
  input  wire logic       ext_irq_zero_en,
  input  wire logic       ext_irq_one_en,
  input  wire logic       kbd_irq,
  input  wire logic       usb_irq,
  input  wire logic       power_rise,
  input  wire logic       ext_program_mem,
  input  wire logic       ale_core,
  input  wire logic       program_fetch_strobe_core,
  input  wire logic [7:0] port0_latch,
  input  wire logic [7:0] port0_bus,
  input  wire logic [7:0] port0_bus_oe,
  input  wire logic [7:0] port2_latch,
  input  wire logic [7:0] port2_addr,
  output logic            cpu_clk_en,
  output logic            periph_clk_en,
  output logic            osc_run,
  output logic            ale,
  output logic            program_fetch_strobe,
  output logic      [7:0] port0_out,
  output logic      [7:0] port0_oe,
  output logic      [7:0] port2_out,
  output logic            baud_doubler,
  output logic            framing_error_select
);
  ipdc_wake_if wake ();

  ipdc_wake_timer #(
    .CYCLES (WAKE_CYCLES)
  ) u_wake (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .wake    (wake)
  );

  // External interrupt pins: three stages, change when last two agree
  logic [1:0] ext_s1;
  logic [1:0] ext_s2;
  logic [1:0] ext_s3;
  logic [1:0] ext_lvl;
  logic [1:0] next_ext_lvl;

  always_comb begin
    next_ext_lvl = ext_lvl;
    for (int i = 0; i < 2; i++) begin
      if (ext_s2[i] == ext_s3[i]) begin
        next_ext_lvl[i] = ext_s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ext_s1  <= 2'h3;
      ext_s2  <= 2'h3;
      ext_s3  <= 2'h3;
      ext_lvl <= 2'h3;
    end else begin
      ext_s1  <= {ext_irq_one_n, ext_irq_zero_n};
      ext_s2  <= ext_s1;
      ext_s3  <= ext_s2;
      ext_lvl <= next_ext_lvl;
    end
  end

  // Main state and register bits
  ipdc_state_type state;
  ipdc_state_type next_state;
  logic [7:0]     power_control;
  logic [7:0]     next_power_control;
  logic [1:0]     low_seen;
  logic [1:0]     next_low_seen;
  logic [1:0]     ext_en;
  logic [1:0]     ext_low;
  logic           wr_hit;

  assign ext_en  = {ext_irq_one_en, ext_irq_zero_en};
  assign ext_low = ext_en & ~ext_lvl;
  assign wr_hit  = sfr_wr && (sfr_addr == POWER_CONTROL_ADDR);

  always_comb begin
    next_state    = state;
    next_power_control     = power_control;
    next_low_seen = low_seen;
    wake.start    = 1'b0;
    // Software write; flags have no effect on hardware
    if (wr_hit) begin
      next_power_control = sfr_wdata;
    end
    next_power_control[BIT_RESERVED] = 1'b0;
    if (power_rise) begin
      next_power_control[BIT_POWER_OFF] = 1'b1;
    end
    unique case (state)
      ST_RUN: begin
        // Power-down wins when both bits are set
        if (instr_done && power_control[BIT_PD_REQ]) begin
          next_state = ST_PD;
        end else if (instr_done && power_control[BIT_IDLE_REQ]) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (irq_any) begin
          next_state = ST_RUN;
          // A fresh software set in the same cycle still wins
          if (!(wr_hit && sfr_wdata[BIT_IDLE_REQ])) begin
            next_power_control[BIT_IDLE_REQ] = 1'b0;
          end
        end
      end
      ST_PD: begin
        // Only the four enabled wake sources; reset acts through nrst
        if (ext_low != 2'h0) begin
          next_state    = ST_PD_EXT;
          next_low_seen = ext_low;
        end else if (kbd_irq) begin
          next_state = ST_PD_KWAIT;
          wake.start = 1'b1;
        end else if (usb_irq) begin
          next_state = ST_RUN;
        end
      end
      ST_PD_EXT: begin
        next_low_seen = low_seen | ext_low;
        // First released input completes the exit
        if ((low_seen & ext_lvl & ext_en) != 2'h0) begin
          next_state = ST_RUN;
        end
      end
      ST_PD_KWAIT: begin
        if (wake.done) begin
          next_state = ST_RUN;
        end
      end
    endcase
    // Both request bits drop when a power-down exit hands back to the CPU
    if (state inside {ST_PD, ST_PD_EXT, ST_PD_KWAIT} && next_state == ST_RUN) begin
      next_power_control[BIT_PD_REQ]   = 1'b0;
      next_power_control[BIT_IDLE_REQ] = 1'b0;
      next_low_seen           = 2'h0;
    end
  end

  // Reset clears every bit; interrupt exits clear only the request bits
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state    <= ST_RUN;
      power_control     <= POWER_CONTROL_RESET;
      low_seen <= 2'h0;
    end else begin
      state    <= next_state;
      power_control     <= next_power_control;
      low_seen <= next_low_seen;
    end
  end

  // Registered outputs, computed from the next state
  logic       next_cpu_clk_en;
  logic       next_periph_clk_en;
  logic       next_osc_run;
  logic       next_ale;
  logic       next_fetch;
  logic [7:0] next_p0_out;
  logic [7:0] next_p0_oe;
  logic [7:0] next_p2_out;
  logic [7:0] next_rdata;
  logic       low_power;

  always_comb begin
    low_power = (next_state != ST_RUN);
    // CPU stops without losing state; the rest stays clocked in idle
    next_cpu_clk_en    = !low_power;
    next_periph_clk_en = next_state inside {ST_RUN, ST_IDLE};
    next_osc_run       = (next_state != ST_PD);
    next_ale           = ale_core;
    next_fetch         = program_fetch_strobe_core;
    if (next_state == ST_IDLE) begin
      next_ale   = 1'b1;
      next_fetch = 1'b1;
    end else if (low_power) begin
      next_ale   = 1'b0;
      next_fetch = 1'b0;
    end
    // Port zero: open drain from the latch unless it carries the bus
    next_p0_out = 8'h00;
    next_p0_oe  = ~port0_latch;
    if (ext_program_mem) begin
      next_p0_out = low_power ? 8'h00 : port0_bus;
      next_p0_oe  = low_power ? 8'h00 : port0_bus_oe;
    end
    // Address stays out only in idle; power-down shows latched data
    next_p2_out = port2_latch;
    if (ext_program_mem && next_state inside {ST_RUN, ST_IDLE}) begin
      next_p2_out = port2_addr;
    end
    next_rdata = (sfr_addr == POWER_CONTROL_ADDR) ? power_control : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_clk_en           <= 1'b1;
      periph_clk_en        <= 1'b1;
      osc_run              <= 1'b1;
      ale                  <= 1'b1;
      program_fetch_strobe <= 1'b1;
      port0_out            <= 8'h00;
      port0_oe             <= 8'h00;
      port2_out            <= 8'h00;
      sfr_rdata            <= 8'h00;
      baud_doubler         <= 1'b0;
      framing_error_select <= 1'b0;
    end else begin
      cpu_clk_en           <= next_cpu_clk_en;
      periph_clk_en        <= next_periph_clk_en;
      osc_run              <= next_osc_run;
      ale                  <= next_ale;
      program_fetch_strobe <= next_fetch;
      port0_out            <= next_p0_out;
      port0_oe             <= next_p0_oe;
      port2_out            <= next_p2_out;
      sfr_rdata            <= next_rdata;
      baud_doubler         <= next_power_control[BIT_BAUD_DBL];
      framing_error_select <= next_power_control[BIT_FRAME_SEL];
    end
  end

  // Helper: cycles spent in the keyboard wait
  logic [15:0] kw_cnt;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      kw_cnt <= 16'h0000;
    end else begin
      kw_cnt <= (state == ST_PD_KWAIT) ? kw_cnt + 16'h0001 : 16'h0000;
    end
  end

  sequence s_idle_entry;
    state == ST_RUN && power_control[BIT_IDLE_REQ] && !power_control[BIT_PD_REQ] && instr_done;
  endsequence
  sequence s_idle_held;
    state == ST_IDLE && !cpu_clk_en && periph_clk_en;
  endsequence

  property p_idle_entry;
    @(posedge clk_sys) disable iff (!nrst) s_idle_entry |=> s_idle_held;
  endproperty
  a_idle_entry: assert property (p_idle_entry)
    else $error("idle not entered with cpu clock gated");

  property p_idle_exit;
    @(posedge clk_sys) disable iff (!nrst)
      (state == ST_IDLE && irq_any && !wr_hit) |=>
        (state == ST_RUN && cpu_clk_en && !power_control[BIT_IDLE_REQ]);
  endproperty
  a_idle_exit: assert property (p_idle_exit)
    else $error("idle not ended by interrupt");

  property p_both_bits;
    @(posedge clk_sys) disable iff (!nrst)
      (state == ST_RUN && power_control[BIT_PD_REQ] && instr_done) |=> (state == ST_PD && !osc_run);
  endproperty
  a_both_bits: assert property (p_both_bits)
    else $error("power-down not entered or oscillator running");

  property p_kbd_wait;
    @(posedge clk_sys) disable iff (!nrst)
      (state == ST_PD_KWAIT && wake.done) |-> kw_cnt == 16'(WAKE_CYCLES - 1);
  endproperty
  a_kbd_wait: assert property (p_kbd_wait)
    else $error("keyboard wake delay wrong length");

  property p_ext_restart;
    @(posedge clk_sys) disable iff (!nrst)
      (state == ST_PD && ext_low != 2'h0) |=> (osc_run && !cpu_clk_en) [*2];
  endproperty
  a_ext_restart: assert property (p_ext_restart)
    else $error("oscillator not restarted by held interrupt");

  property p_exit_clears;
    @(posedge clk_sys) disable iff (!nrst)
      (state != ST_RUN && state != ST_IDLE) ##1 (state == ST_RUN) |->
        !power_control[BIT_PD_REQ] && !power_control[BIT_IDLE_REQ];
  endproperty
  a_exit_clears: assert property (p_exit_clears)
    else $error("request bits not cleared on power-down exit");

  property p_strobes;
    @(posedge clk_sys) disable iff (!nrst)
      (state == ST_IDLE |-> ale && program_fetch_strobe) and
      (state == ST_PD |-> !ale && !program_fetch_strobe);
  endproperty
  a_strobes: assert property (p_strobes)
    else $error("strobe level wrong in low-power mode");

  property p_port0_zero;
    @(posedge clk_sys) disable iff (!nrst)
      (state != ST_RUN) |-> port0_out == 8'h00;
  endproperty
  a_port0_zero: assert property (p_port0_zero)
    else $error("port zero drives a one while held");

  property p_reserved;
    @(posedge clk_sys) disable iff (!nrst) !sfr_rdata[BIT_RESERVED] && !power_control[BIT_RESERVED];
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bit reads one");

  property p_flags;
    @(posedge clk_sys) disable iff (!nrst)
      wr_hit |=> power_control[BIT_GFLAG_B:BIT_GFLAG_A] == $past(sfr_wdata[BIT_GFLAG_B:BIT_GFLAG_A]);
  endproperty
  a_flags: assert property (p_flags)
    else $error("general flags not stored");
endmodule
`default_nettype wire

// ### ipdc_core_model.sv
// Behavioural core model: instruction completions and bus strobes
`timescale 1ns/1ps
`default_nettype none
module ipdc_core_model (
  input  wire logic clk_sys,
  input  wire logic nrst,
  input  wire logic cpu_clk_en,
  output logic      instr_done,
  output logic      ale_core,
  output logic      program_fetch_strobe_core
);
  int phase;

  initial begin
    phase = 0;
    instr_done = 1'b0;
    ale_core = 1'b1;
    program_fetch_strobe_core = 1'b1;
  end

  // Instructions complete only while the core is clocked, one every third cycle
  always @(posedge clk_sys) begin
    #1;
    if (!nrst || !cpu_clk_en) phase = 0;
    else phase = (phase + 1) % 3;
    instr_done = nrst && cpu_clk_en && phase == 2;
    ale_core = (phase != 0);
    program_fetch_strobe_core = (phase != 1);
  end
endmodule
`default_nettype wire

// ### idle_powerdown_control_bench.sv
// Self-checking bench for the idle and power-down controller
`timescale 1ns/1ps
`default_nettype none
module idle_powerdown_control_bench;
  import ipdc_pkg::*;
  localparam int W = 8;
  logic       clk_sys, nrst, sfr_wr, irq_any, z_n, o_n, z_en, o_en, kbd, usb, prise, ext_mem;
  logic       instr_done, ale_core, pfs_core, cpu_clk_en, periph, osc, ale, pfs, baud, frame;
  logic [7:0] sfr_addr, sfr_wdata, rdata, p0l, p0b, p0boe, p2l, p2a, p0_out, p0_oe, p2_out;
  logic [7:0] v, d;
  logic [31:0] seed = 32'h9;
  int         n, miscompares = 0, n_checks = 0;

  ipdc_power_ctrl #(.WAKE_CYCLES(W)) ipdc_power_ctrl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(rdata), .instr_done(instr_done), .irq_any(irq_any),
    .ext_irq_zero_n(z_n), .ext_irq_one_n(o_n), .ext_irq_zero_en(z_en), .ext_irq_one_en(o_en),
    .kbd_irq(kbd), .usb_irq(usb), .power_rise(prise), .ext_program_mem(ext_mem),
    .ale_core(ale_core), .program_fetch_strobe_core(pfs_core), .port0_latch(p0l),
    .port0_bus(p0b), .port0_bus_oe(p0boe), .port2_latch(p2l), .port2_addr(p2a),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph), .osc_run(osc), .ale(ale),
    .program_fetch_strobe(pfs), .port0_out(p0_out), .port0_oe(p0_oe), .port2_out(p2_out),
    .baud_doubler(baud), .framing_error_select(frame));

  ipdc_core_model ipdc_core_model_inst (
    .clk_sys(clk_sys), .nrst(nrst), .cpu_clk_en(cpu_clk_en), .instr_done(instr_done),
    .ale_core(ale_core), .program_fetch_strobe_core(pfs_core));

  // Free-running system clock, 4 ns period
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  // Reserved bit never holds a one
  function automatic logic [7:0] exp_power_control(input logic [7:0] w);
    return w & 8'hdf;
  endfunction

  function automatic logic sig(input int sel);
    return (sel == 0) ? cpu_clk_en : osc;
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    sfr_addr = a;
    sfr_wdata = w;
    sfr_wr = 1'b1;
    tick();
    sfr_wr = 1'b0;
    sfr_addr = POWER_CONTROL_ADDR;
  endtask

  // Read data is registered from the address of the previous edge
  task automatic rd(output logic [7:0] r);
    tick();
    r = rdata;
  endtask

  // Bounded wait for a controller output to reach a level
  task automatic wait_for(input int sel, input logic lvl, input int max, output int cnt);
    cnt = 0;
    while (sig(sel) !== lvl && cnt <= max) begin
      tick();
      cnt++;
    end
    if (cnt > max) chk(8'hee, 8'(lvl));
  endtask

  task automatic finish_test();
    $display("checks %0d, miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #40000;
    miscompares++;
    finish_test();
  end

  initial begin
    {nrst, sfr_wr, irq_any, z_en, o_en, kbd, usb, prise, ext_mem} = '0;
    {z_n, o_n} = 2'b11;
    sfr_addr = POWER_CONTROL_ADDR;
    {sfr_wdata, p0l, p0b, p0boe, p2l, p2a} = '0;
    repeat (8) @(posedge clk_sys);
    #1 nrst = 1'b1;
    rd(v);
    chk(v, POWER_CONTROL_RESET);
    chk(8'({cpu_clk_en, periph, osc}), 8'h07);
    // Random register traffic with mode bits kept clear, first an all-ones corner
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 8'hfc : (rnd() & 8'hfc);
      wr(POWER_CONTROL_ADDR, d);
      rd(v);
      chk(v, exp_power_control(d));
      chk(8'({baud, frame}), 8'(d[7:6]));
    end
    wr(8'h88, 8'h03);
    sfr_addr = 8'h88;
    tick();
    chk(rdata, 8'h00);
    sfr_addr = POWER_CONTROL_ADDR;
    rd(v);
    chk(v, exp_power_control(d));
    prise = 1'b1;
    tick();
    prise = 1'b0;
    rd(v);
    chk(v & 8'h10, 8'h10);
    // Idle with internal then external program memory
    for (int e = 0; e < 2; e++) begin
      ext_mem = e[0];
      p0l = rnd();
      p2l = rnd();
      p2a = rnd();
      p0b = rnd();
      p0boe = rnd();
      wr(POWER_CONTROL_ADDR, 8'h0d);
      wait_for(0, 1'b0, 20, n);
      chk(8'({periph, osc, ale, pfs}), 8'h0f);
      repeat (3) tick();
      chk(p2_out, e ? p2a : p2l);
      chk(p0_oe, e ? 8'h00 : ~p0l);
      irq_any = 1'b1;
      wait_for(0, 1'b1, 4, n);
      irq_any = 1'b0;
      rd(v);
      chk(v & 8'h0f, 8'h0c);
    end
    ext_mem = 1'b0;
    // Power-down, stray interrupt ignored, keyboard wake after the delay
    wr(POWER_CONTROL_ADDR, 8'h0e);
    wait_for(0, 1'b0, 20, n);
    repeat (2) tick();
    chk(8'({periph, osc, ale, pfs}), 8'h00);
    chk(p0_out, 8'h00);
    chk(p0_oe, ~p0l);
    irq_any = 1'b1;
    repeat (8) tick();
    chk(8'(cpu_clk_en), 8'h00);
    irq_any = 1'b0;
    kbd = 1'b1;
    wait_for(0, 1'b1, W + 4, n);
    kbd = 1'b0;
    chk(8'(n), 8'(W + 1));
    rd(v);
    chk(v & 8'h0f, 8'h0c);
    // Both mode bits set, wake by each external pin in turn
    for (int k = 0; k < 2; k++) begin
      wr(POWER_CONTROL_ADDR, 8'h0f);
      wait_for(0, 1'b0, 20, n);
      repeat (2) tick();
      z_en = (k == 0);
      o_en = (k == 1);
      if (k == 0) z_n = 1'b0;
      else o_n = 1'b0;
      wait_for(1, 1'b1, 8, n);
      repeat (3) tick();
      chk(8'(cpu_clk_en), 8'h00);
      {z_n, o_n} = 2'b11;
      wait_for(0, 1'b1, 10, n);
      rd(v);
      chk(v & 8'h0f, 8'h0c);
    end
    {z_en, o_en} = 2'b00;
    // USB wake, then reset out of power-down
    wr(POWER_CONTROL_ADDR, 8'h0e);
    wait_for(0, 1'b0, 20, n);
    usb = 1'b1;
    wait_for(0, 1'b1, 4, n);
    usb = 1'b0;
    wr(POWER_CONTROL_ADDR, 8'h0e);
    wait_for(0, 1'b0, 20, n);
    nrst = 1'b0;
    repeat (24) tick();
    nrst = 1'b1;
    rd(v);
    chk(v, POWER_CONTROL_RESET);
    chk(8'(cpu_clk_en), 8'h01);
    finish_test();
  end
endmodule
`default_nettype wire
